// ---- rtl/sync_mode_status_pin_control.sv ----
// Serial-programmed sync, mode and status-pin control bank
`timescale 1ns/10ps
`default_nettype none
module sync_mode_status_pin_control
  import sync_pin_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // Serial programming port
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  input wire logic SER_LE,
  // Sync pin
  input wire logic SYNC_PIN_I,
  output logic SYNC_PIN_O,
  output logic SYNC_PIN_OE,
  output logic SYNC_PULL_UP,
  output logic SYNC_PULL_DOWN,
  // Lock status pin
  output logic LOCK_PIN_O,
  output logic LOCK_PIN_OE,
  // Analog side status
  input wire logic REF2_LOSS,
  input wire logic REF2_SELECTED,
  input wire lock_status_t LOCK_STATUS,
  // Output clock phase ticks and output two divider power-down
  input wire logic [5:0] OUT_TICK,
  input wire logic EXT_FB_TICK,
  input wire logic OUTPUT_TWO_DIVIDER_POWERDOWN,
  // Controls to the analog side
  output logic FEEDBACK_CLOCK,
  output logic FEEDBACK_MUX_POWER,
  output logic CRYSTAL_AMP_ENABLE,
  output mode_ctrl_t MODE_CTRL,
  // Output synchronization
  output logic SYNC_ACTIVE,
  output logic [5:0] CLKOUT_HOLD_LOW,
  output logic [5:0] DELAY_LOAD
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARM = 4'b0010,
    ST_HOLD = 4'b0100,
    ST_DISARM = 4'b1000
  } sync_state_t;

  output_path_t r10;
  mode_sync_t r11;
  lock_pin_t r12;
  logic [31:0] shift_in;
  logic [31:0] readback;
  logic ser_clk_q;
  logic ser_le_q;
  logic auto_armed;
  logic en_q;
  logic pol_q;
  logic [5:0] part;
  sync_state_t state;
  sync_state_t next_state;

  wire logic ser_rise = SER_CLK & ~ser_clk_q;
  wire logic le_rise = SER_LE & ~ser_le_q;
  wire logic le_fall = ~SER_LE & ser_le_q;
  wire logic [4:0] wr_addr = shift_in[4:0];
  wire logic readback_bit = readback[WORD_BITS-1];

  // Serial shift and word latch
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ser_clk_q <= 1'b0;
      ser_le_q <= 1'b0;
      shift_in <= 32'h00000000;
    end else begin
      ser_clk_q <= SER_CLK;
      ser_le_q <= SER_LE;
      if (ser_rise && !SER_LE) begin
        shift_in <= {shift_in[30:0], SER_DATA};
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      r10 <= RESET_OUTPUT_PATH_CONFIG;
      r11 <= RESET_DEVICE_MODE_SYNC_CONFIG;
      r12 <= RESET_LOCK_PIN_SYNC_LOCK_CONFIG;
    end else if (le_rise) begin
      case (wr_addr)
        ADDR_OUTPUT_PATH_CONFIG: r10 <= shift_in;
        ADDR_DEVICE_MODE_SYNC_CONFIG: r11 <= shift_in;
        ADDR_LOCK_PIN_SYNC_LOCK_CONFIG: r12 <= shift_in;
        default: ;
      endcase
    end
  end

  // Readback of the word addressed by the last latch, shifted MSB first
  always_ff @(posedge MCLK) begin
    if (RST) begin
      readback <= 32'h00000000;
    end else if (le_rise) begin
      case (wr_addr)
        ADDR_OUTPUT_PATH_CONFIG: readback <= r10;
        ADDR_DEVICE_MODE_SYNC_CONFIG: readback <= r11;
        ADDR_LOCK_PIN_SYNC_LOCK_CONFIG: readback <= r12;
        default: readback <= 32'h00000000;
      endcase
    end else if (ser_rise && !SER_LE) begin
      readback <= {readback[30:0], 1'b0};
    end
  end

  // Auto sync: delay registers are 0..5; event lands on the latch fall
  always_ff @(posedge MCLK) begin
    if (RST) begin
      auto_armed <= 1'b0;
    end else if (le_rise) begin
      auto_armed <= (wr_addr <= ADDR_LAST_DELAY_REG);
    end else if (le_fall) begin
      auto_armed <= 1'b0;
    end
  end

  wire logic auto_pulse = le_fall & auto_armed & r11.auto_sync;

  // Edge memories for enable and polarity events
  always_ff @(posedge MCLK) begin
    if (RST) begin
      en_q <= 1'b1;
      pol_q <= 1'b0;
    end else begin
      en_q <= r11.sync_enable;
      pol_q <= r11.sync_polarity_invert;
    end
  end

  wire logic en_rise = r11.sync_enable & ~en_q;

  // Output-type pin reads as 0, so the polarity bit alone asserts sync
  wire logic pin_is_output = r11.sync_pin_io_type >= PIN_PUSH_PULL;
  wire logic pin_level = pin_is_output ? 1'b0 : SYNC_PIN_I;
  wire logic pin_assert = pin_level ^ r11.sync_polarity_invert;

  // Qualification falls back to plain sync if output two divider is off
  wire logic qual_eff = r11.sync_qualify_by_output & ~OUTPUT_TWO_DIVIDER_POWERDOWN;
  wire logic hold_lock = ~r11.sync_qualify_by_output &
    ((r12.sync_hold_until_second_lock & ~LOCK_STATUS.second_lock) |
     (r12.sync_hold_until_first_lock & ~LOCK_STATUS.first_lock));
  wire logic sync_req = pin_assert | hold_lock | auto_pulse | en_rise;

  logic fb_tick;
  always_comb begin
    case (r10.feedback_select)
      FB_OUT1: fb_tick = OUT_TICK[1];
      FB_OUT3: fb_tick = OUT_TICK[3];
      FB_OUT4: fb_tick = OUT_TICK[4];
      FB_OUT5: fb_tick = OUT_TICK[5];
      FB_EXTERNAL: fb_tick = EXT_FB_TICK;
      default: fb_tick = 1'b0;
    endcase
  end

  // Sync sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (sync_req) begin
          next_state = qual_eff ? ST_ARM : ST_HOLD;
        end
      end
      ST_ARM: begin
        if (fb_tick) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!sync_req) begin
          next_state = qual_eff ? ST_DISARM : ST_IDLE;
        end
      end
      ST_DISARM: begin
        if (fb_tick) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (!r11.sync_enable) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  wire logic sync_on = (state == ST_HOLD) || (state == ST_DISARM);

  // Participants are fixed at the start so later exclusions cannot cut in
  always_ff @(posedge MCLK) begin
    if (RST) begin
      part <= 6'h00;
    end else if (state == ST_IDLE || state == ST_ARM) begin
      part <= ~r11.per_output_sync_exclude;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      SYNC_ACTIVE <= 1'b0;
      CLKOUT_HOLD_LOW <= 6'h00;
      DELAY_LOAD <= 6'h00;
    end else begin
      SYNC_ACTIVE <= sync_on;
      CLKOUT_HOLD_LOW <= sync_on ? part : 6'h00;
      DELAY_LOAD <= (sync_on && next_state == ST_IDLE) ? part : 6'h00;
    end
  end

  // Mode decode
  mode_ctrl_t next_mode;
  always_comb begin
    next_mode = '0;
    next_mode.mode_valid = 1'b1;
    case (r11.mode)
      MODE_DUAL_INT, MODE_DUAL_INT_ZD, MODE_DUAL_EXT, MODE_DUAL_EXT_ZD: begin
        next_mode.first_loop_on = 1'b1;
        next_mode.second_loop_on = 1'b1;
      end
      MODE_SINGLE_INT, MODE_SINGLE_INT_ZD, MODE_SINGLE_EXT: begin
        next_mode.second_loop_on = 1'b1;
        next_mode.ref_from_oscillator = 1'b1;
      end
      MODE_DISTRIBUTION: begin
        next_mode.ref1_to_outputs = 1'b1;
        next_mode.oscillator_to_buffered = 1'b1;
      end
      default: next_mode.mode_valid = 1'b0;
    endcase
    next_mode.internal_vco = next_mode.second_loop_on &&
      (r11.mode == MODE_DUAL_INT || r11.mode == MODE_DUAL_INT_ZD ||
       r11.mode == MODE_SINGLE_INT || r11.mode == MODE_SINGLE_INT_ZD);
    next_mode.zero_delay = (r11.mode == MODE_DUAL_INT_ZD) || (r11.mode == MODE_DUAL_EXT_ZD) ||
      (r11.mode == MODE_SINGLE_INT_ZD);
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      MODE_CTRL <= '0;
      FEEDBACK_CLOCK <= 1'b0;
      FEEDBACK_MUX_POWER <= 1'b0;
      CRYSTAL_AMP_ENABLE <= 1'b0;
    end else begin
      MODE_CTRL <= next_mode;
      FEEDBACK_CLOCK <= fb_tick & next_mode.zero_delay;
      FEEDBACK_MUX_POWER <= r10.feedback_mux_power;
      CRYSTAL_AMP_ENABLE <= r11.crystal_amp_enable;
    end
  end

  // Sync pin source and drive
  logic sync_src;
  always_comb begin
    case (r11.sync_pin_output_select)
      SPS_REF2_LOSS: sync_src = REF2_LOSS;
      SPS_REF2_SELECTED: sync_src = REF2_SELECTED;
      SPS_READBACK: sync_src = readback_bit;
      default: sync_src = 1'b0;
    endcase
  end

  // Lock pin source
  logic lock_src;
  always_comb begin
    case (r12.lock_pin_output_select)
      5'h01: lock_src = LOCK_STATUS.first_lock;
      5'h02: lock_src = LOCK_STATUS.second_lock;
      5'h03: lock_src = LOCK_STATUS.first_lock & LOCK_STATUS.second_lock;
      5'h04: lock_src = LOCK_STATUS.holdover;
      5'h05: lock_src = LOCK_STATUS.dac_locked;
      5'h07: lock_src = readback_bit;
      5'h08: lock_src = LOCK_STATUS.dac_rail;
      5'h09: lock_src = LOCK_STATUS.dac_low;
      5'h0a: lock_src = LOCK_STATUS.dac_high;
      5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12:
        lock_src = LOCK_STATUS.divider_taps[3'(r12.lock_pin_output_select - 5'h0b)];
      default: lock_src = 1'b0;
    endcase
  end

  // Open source drives only high, open drain only low
  always_ff @(posedge MCLK) begin
    if (RST) begin
      SYNC_PIN_O <= 1'b0;
      SYNC_PIN_OE <= 1'b0;
      SYNC_PULL_UP <= 1'b0;
      SYNC_PULL_DOWN <= 1'b0;
    end else begin
      SYNC_PULL_UP <= r11.sync_pin_io_type == PIN_INPUT_PULL_UP;
      SYNC_PULL_DOWN <= r11.sync_pin_io_type == PIN_INPUT_PULL_DOWN;
      case (r11.sync_pin_io_type)
        PIN_PUSH_PULL: {SYNC_PIN_O, SYNC_PIN_OE} <= {sync_src, 1'b1};
        PIN_PUSH_PULL_INV: {SYNC_PIN_O, SYNC_PIN_OE} <= {~sync_src, 1'b1};
        PIN_OPEN_SOURCE: {SYNC_PIN_O, SYNC_PIN_OE} <= {1'b1, sync_src};
        PIN_OPEN_DRAIN: {SYNC_PIN_O, SYNC_PIN_OE} <= {1'b0, ~sync_src};
        default: {SYNC_PIN_O, SYNC_PIN_OE} <= 2'b00;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      LOCK_PIN_O <= 1'b0;
      LOCK_PIN_OE <= 1'b0;
    end else begin
      case (r12.lock_pin_io_type)
        PIN_PUSH_PULL: {LOCK_PIN_O, LOCK_PIN_OE} <= {lock_src, 1'b1};
        PIN_PUSH_PULL_INV: {LOCK_PIN_O, LOCK_PIN_OE} <= {~lock_src, 1'b1};
        PIN_OPEN_SOURCE: {LOCK_PIN_O, LOCK_PIN_OE} <= {1'b1, lock_src};
        PIN_OPEN_DRAIN: {LOCK_PIN_O, LOCK_PIN_OE} <= {1'b0, ~lock_src};
        default: {LOCK_PIN_O, LOCK_PIN_OE} <= 2'b00;
      endcase
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  chk_enable_rise_sync: assert property (en_rise && !qual_eff |=> state == ST_HOLD)
    else $error("sync enable rise did not start sync");
  chk_disabled_idle: assert property (!r11.sync_enable |=> state == ST_IDLE ##1 !SYNC_ACTIVE)
    else $error("sync ran while disabled");
  chk_excluded_free: assert property ((CLKOUT_HOLD_LOW & ~$past(part)) == 6'h00)
    else $error("excluded output held low");
  chk_hold_low_part: assert property (sync_on |=> CLKOUT_HOLD_LOW == $past(part) && SYNC_ACTIVE)
    else $error("participant not held low");
  chk_delay_on_exit: assert property (sync_on && next_state == ST_IDLE |=> DELAY_LOAD == $past(part))
    else $error("delay load mismatch at sync end");
  chk_output_pin_low: assert property (pin_is_output && !r11.sync_polarity_invert |-> !pin_assert)
    else $error("output-type pin asserted sync");
  chk_auto_sync_fall: assert property (le_fall && auto_armed && r11.auto_sync && r11.sync_enable
    && !qual_eff && state == ST_IDLE |=> state == ST_HOLD)
    else $error("auto sync missed latch fall");
  chk_hold_for_lock: assert property (r11.sync_enable && r12.sync_hold_until_second_lock &&
    !r11.sync_qualify_by_output && !LOCK_STATUS.second_lock && state == ST_HOLD |=> state == ST_HOLD)
    else $error("sync released before lock");
  chk_qual_wait: assert property (state == ST_ARM && !fb_tick && r11.sync_enable |=> state == ST_ARM)
    else $error("qualified sync started off tick");
  chk_lock_pin_inv: assert property (r12.lock_pin_output_select == 5'h00 &&
    r12.lock_pin_io_type == PIN_PUSH_PULL_INV |=> LOCK_PIN_O && LOCK_PIN_OE)
    else $error("inverted low source not high");
  chk_sync_pin_src: assert property (r11.sync_pin_io_type == PIN_PUSH_PULL &&
    r11.sync_pin_output_select == SPS_REF2_LOSS |=> SYNC_PIN_O == $past(REF2_LOSS))
    else $error("sync pin source wrong");

  cov_enable_sync: cover property (en_rise ##[1:4] SYNC_ACTIVE);
  cov_auto_sync: cover property (auto_pulse ##[1:4] DELAY_LOAD != 6'h00);
  cov_qualified: cover property (state == ST_ARM ##[1:50] state == ST_DISARM);
  cov_polarity_toggle: cover property (r11.sync_polarity_invert != pol_q ##1 SYNC_ACTIVE);

endmodule : sync_mode_status_pin_control
`default_nettype wire

// ---- rtl/sync_pin_pkg.sv ----
// Constants, field layouts and types for the sync, mode and status-pin control bank
package sync_pin_pkg;
  localparam logic [4:0] ADDR_OUTPUT_PATH_CONFIG = 5'h0a;
  localparam logic [4:0] ADDR_DEVICE_MODE_SYNC_CONFIG = 5'h0b;
  localparam logic [4:0] ADDR_LOCK_PIN_SYNC_LOCK_CONFIG = 5'h0c;
  localparam logic [4:0] ADDR_LAST_DELAY_REG = 5'h05;
  localparam logic [31:0] RESET_OUTPUT_PATH_CONFIG = 32'h0000002a;
  localparam logic [31:0] RESET_DEVICE_MODE_SYNC_CONFIG = 32'h0400000b;
  localparam logic [31:0] RESET_LOCK_PIN_SYNC_LOCK_CONFIG = 32'h1300000c;
  localparam int WORD_BITS = 32;
  localparam int NUM_OUTPUTS = 6;
  // Feedback select codes
  localparam logic [2:0] FB_OUT1 = 3'h1;
  localparam logic [2:0] FB_OUT3 = 3'h3;
  localparam logic [2:0] FB_OUT4 = 3'h4;
  localparam logic [2:0] FB_OUT5 = 3'h5;
  localparam logic [2:0] FB_EXTERNAL = 3'h6;
  // Device mode codes
  localparam logic [4:0] MODE_DUAL_INT = 5'h00;
  localparam logic [4:0] MODE_DUAL_INT_ZD = 5'h02;
  localparam logic [4:0] MODE_DUAL_EXT = 5'h03;
  localparam logic [4:0] MODE_DUAL_EXT_ZD = 5'h05;
  localparam logic [4:0] MODE_SINGLE_INT = 5'h06;
  localparam logic [4:0] MODE_SINGLE_INT_ZD = 5'h08;
  localparam logic [4:0] MODE_SINGLE_EXT = 5'h0b;
  localparam logic [4:0] MODE_DISTRIBUTION = 5'h10;
  // Pin type codes, shared by sync and lock pins
  localparam logic [2:0] PIN_INPUT = 3'h0;
  localparam logic [2:0] PIN_INPUT_PULL_UP = 3'h1;
  localparam logic [2:0] PIN_INPUT_PULL_DOWN = 3'h2;
  localparam logic [2:0] PIN_PUSH_PULL = 3'h3;
  localparam logic [2:0] PIN_PUSH_PULL_INV = 3'h4;
  localparam logic [2:0] PIN_OPEN_SOURCE = 3'h5;
  localparam logic [2:0] PIN_OPEN_DRAIN = 3'h6;
  // Sync pin output select codes
  localparam logic [1:0] SPS_LOW = 2'h0;
  localparam logic [1:0] SPS_REF2_LOSS = 2'h1;
  localparam logic [1:0] SPS_REF2_SELECTED = 2'h2;
  localparam logic [1:0] SPS_READBACK = 2'h3;

  typedef struct packed {
    logic [19:0] upper;
    logic feedback_mux_power;
    logic [2:0] middle;
    logic [2:0] feedback_select;
    logic [4:0] addr;
  } output_path_t;

  typedef struct packed {
    logic [4:0] mode;
    logic sync_enable;
    logic [5:0] per_output_sync_exclude;
    logic [1:0] sync_pin_output_select;
    logic sync_qualify_by_output;
    logic sync_polarity_invert;
    logic auto_sync;
    logic [2:0] sync_pin_io_type;
    logic [5:0] spare;
    logic crystal_amp_enable;
    logic [4:0] addr;
  } mode_sync_t;

  typedef struct packed {
    logic [4:0] lock_pin_output_select;
    logic [2:0] lock_pin_io_type;
    logic sync_hold_until_second_lock;
    logic sync_hold_until_first_lock;
    logic [16:0] rest;
    logic [4:0] addr;
  } lock_pin_t;

  typedef struct packed {
    logic mode_valid;
    logic first_loop_on;
    logic second_loop_on;
    logic internal_vco;
    logic zero_delay;
    logic ref_from_oscillator;
    logic ref1_to_outputs;
    logic oscillator_to_buffered;
  } mode_ctrl_t;

  typedef struct packed {
    logic first_lock;
    logic second_lock;
    logic holdover;
    logic dac_locked;
    logic dac_rail;
    logic dac_low;
    logic dac_high;
    logic [7:0] divider_taps;
  } lock_status_t;
endpackage : sync_pin_pkg

// ---- tb/host_ser_model.sv ----
// Host model that shifts words into the serial programming port
`timescale 1ns/10ps
`default_nettype none
module host_ser_model (
  // Clock
  input wire logic clk,
  // Serial port
  output logic ser_clk,
  output logic ser_data,
  output logic ser_le
);
  int slow = 1;
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    ser_le = 1'b0;
  end
  // Callers pick the words; only one refusal probe uses a reserved code
  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      ser_data = w[i];
      repeat (slow) @(posedge clk);
      #1 ser_clk = 1'b1;
      repeat (slow) @(posedge clk);
      #1 ser_clk = 1'b0;
    end
    // Data line not parked on the last bit, so a stale sample shows
    ser_data = ~w[0];
    repeat (slow) @(posedge clk);
    #1 ser_le = 1'b1;
    repeat (slow) @(posedge clk);
    #1 ser_le = 1'b0;
    @(posedge clk);
    #1;
  endtask : send
endmodule : host_ser_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the sync, mode and status-pin control bank
`timescale 1ns/10ps
`default_nettype none
module tb
  import sync_pin_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic sync_pin = 1'b0;
  logic ref2_loss = 1'b0;
  logic ref2_sel = 1'b0;
  logic [5:0] out_tick = 6'h00;
  logic ext_fb_tick = 1'b0;
  lock_status_t lock_status = '0;
  logic ser_clk, ser_data, ser_le;
  logic sync_o, sync_oe, pull_up, pull_dn, lock_o, lock_oe;
  logic fb_clk, fb_pwr, xtal_en, sync_active, src;
  logic [5:0] hold_low, delay_load, ex;
  logic [6:0] tk;
  logic div2_pd = 1'b0;
  mode_ctrl_t mode_ctrl;
  logic [7:0] rnd = 8'h0c;
  int num_errors = 0;
  int checks_done = 0;
  logic [5:0] exp_q[$];
  output_path_t r10 = RESET_OUTPUT_PATH_CONFIG;
  mode_sync_t r11 = RESET_DEVICE_MODE_SYNC_CONFIG;
  lock_pin_t r12 = RESET_LOCK_PIN_SYNC_LOCK_CONFIG;
  logic [4:0] modes [9] = '{MODE_DUAL_INT, MODE_DUAL_INT_ZD, MODE_DUAL_EXT, MODE_DUAL_EXT_ZD,
    MODE_SINGLE_INT, MODE_SINGLE_INT_ZD, MODE_SINGLE_EXT, MODE_DISTRIBUTION, 5'h01};
  logic [2:0] fbs [5] = '{FB_OUT1, FB_OUT3, FB_OUT4, FB_OUT5, FB_EXTERNAL};

  always #4 mclk = ~mclk;

  sync_mode_status_pin_control sync_mode_status_pin_control_inst (
    .MCLK(mclk),
    .RST(rst),
    .SER_CLK(ser_clk),
    .SER_DATA(ser_data),
    .SER_LE(ser_le),
    .SYNC_PIN_I(sync_oe ? sync_o : sync_pin),
    .SYNC_PIN_O(sync_o),
    .SYNC_PIN_OE(sync_oe),
    .SYNC_PULL_UP(pull_up),
    .SYNC_PULL_DOWN(pull_dn),
    .LOCK_PIN_O(lock_o),
    .LOCK_PIN_OE(lock_oe),
    .REF2_LOSS(ref2_loss),
    .REF2_SELECTED(ref2_sel),
    .LOCK_STATUS(lock_status),
    .OUT_TICK(out_tick),
    .EXT_FB_TICK(ext_fb_tick),
    .OUTPUT_TWO_DIVIDER_POWERDOWN(div2_pd),
    .FEEDBACK_CLOCK(fb_clk),
    .FEEDBACK_MUX_POWER(fb_pwr),
    .CRYSTAL_AMP_ENABLE(xtal_en),
    .MODE_CTRL(mode_ctrl),
    .SYNC_ACTIVE(sync_active),
    .CLKOUT_HOLD_LOW(hold_low),
    .DELAY_LOAD(delay_load)
  );

  host_ser_model host_ser_model_inst (
    .clk(mclk),
    .ser_clk(ser_clk),
    .ser_data(ser_data),
    .ser_le(ser_le)
  );

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  function automatic logic [1:0] drive_of(input logic [2:0] t, input logic s);
    case (t)
      PIN_PUSH_PULL: return {s, 1'b1};
      PIN_PUSH_PULL_INV: return {~s, 1'b1};
      PIN_OPEN_SOURCE: return {1'b1, s};
      PIN_OPEN_DRAIN: return {1'b0, ~s};
      default: return 2'b00;
    endcase
  endfunction : drive_of

  // Valid, loop one, loop two, internal VCO, zero delay, osc reference, ref one out, osc buffered
  function automatic logic [7:0] mode_exp(input logic [4:0] m);
    case (m)
      MODE_DUAL_INT: return 8'hf0;
      MODE_DUAL_INT_ZD: return 8'hf8;
      MODE_DUAL_EXT: return 8'he0;
      MODE_DUAL_EXT_ZD: return 8'he8;
      MODE_SINGLE_INT: return 8'hb4;
      MODE_SINGLE_INT_ZD: return 8'hbc;
      MODE_SINGLE_EXT: return 8'ha4;
      MODE_DISTRIBUTION: return 8'h83;
      default: return 8'h00;
    endcase
  endfunction : mode_exp

  function automatic logic lock_src(input int s, input lock_status_t l);
    case (s)
      0: return 1'b0;
      1: return l.first_lock;
      2: return l.second_lock;
      3: return l.first_lock & l.second_lock;
      4: return l.holdover;
      5: return l.dac_locked;
      8: return l.dac_rail;
      9: return l.dac_low;
      10: return l.dac_high;
      default: return l.divider_taps[s - 11];
    endcase
  endfunction : lock_src

  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : cmp

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // Host pace varies, prompt or slow
  task automatic wr(input logic [31:0] w);
    rnd = lfsr(rnd);
    host_ser_model_inst.slow = 1 + int'(rnd[0]);
    host_ser_model_inst.send(w);
    repeat (4) @(posedge mclk);
    #1;
  endtask : wr

  task automatic held(input logic [5:0] e);
    cmp("sync_active", 32'h1, sync_active);
    cmp("hold_low", {26'h0, ~e}, hold_low);
  endtask : held

  task automatic pin_sync(input logic [5:0] e);
    exp_q.push_back(~e);
    sync_pin = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    held(e);
    sync_pin = 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    cmp("sync_active", 32'h0, sync_active);
  endtask : pin_sync

  // Each load pulse takes the oldest expected participant set
  initial begin
    wait (rst == 1'b0);
    forever begin
      @(negedge mclk);
      if (delay_load !== 6'h00) begin
        if (exp_q.size() == 0)
          cmp("delay_load", 32'h0, delay_load);
        else
          cmp("delay_load", exp_q.pop_front(), delay_load);
      end
    end
  end

  // Roughly three times the expected run
  initial begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    @(posedge mclk);
    #1;
    cmp("mode_ctrl", mode_exp(MODE_DUAL_INT), mode_ctrl);
    cmp("lock_pin", drive_of(PIN_PUSH_PULL, 1'b0), {lock_o, lock_oe});
    pin_sync(6'h00);
    r11.crystal_amp_enable = 1'b1;
    // Last code is reserved, a deliberate refusal probe
    foreach (modes[i]) begin
      r11.mode = modes[i];
      wr(r11);
      cmp("mode_ctrl", mode_exp(modes[i]), mode_ctrl);
    end
    cmp("xtal_amp", 32'h1, xtal_en);
    r11.mode = MODE_DUAL_EXT_ZD;
    wr(r11);
    r10.feedback_mux_power = 1'b1;
    foreach (fbs[i]) begin
      r10.feedback_select = fbs[i];
      wr(r10);
      tk = 7'h01 << (fbs[i] == FB_EXTERNAL ? 6 : fbs[i]);
      {ext_fb_tick, out_tick} = ~tk;
      @(posedge mclk);
      #1;
      cmp("fb_clock", 32'h0, fb_clk);
      {ext_fb_tick, out_tick} = tk;
      @(posedge mclk);
      #1;
      cmp("fb_clock", 32'h1, fb_clk);
      {ext_fb_tick, out_tick} = 7'h00;
    end
    cmp("fb_power", 32'h1, fb_pwr);
    for (int t = 0; t <= 6; t++) begin
      for (int s = 0; s <= 2; s++) begin
        {ref2_loss, ref2_sel} = rnd[1:0];
        r11.sync_pin_io_type = t[2:0];
        r11.sync_pin_output_select = s[1:0];
        wr(r11);
        src = s == 1 ? ref2_loss : (s == 2 && ref2_sel);
        cmp("sync_pin",
          {t < 3 ? 2'b00 : drive_of(t[2:0], src), t == 1, t == 2},
          {t < 3 ? 1'b0 : sync_o, sync_oe, pull_up, pull_dn});
      end
    end
    for (int s = 0; s <= 18; s++) begin
      for (int t = 3; t <= 6; t++) begin
        if (s != 6 && s != 7) begin
          lock_status = {rnd[6:0], lfsr(rnd)};
          r12.lock_pin_output_select = s[4:0];
          r12.lock_pin_io_type = t[2:0];
          wr(r12);
          cmp("lock_pin",
            drive_of(t[2:0], lock_src(s, lock_status)), {lock_o, lock_oe});
        end
      end
    end
    r11.sync_pin_io_type = PIN_INPUT;
    r11.sync_pin_output_select = SPS_LOW;
    r11.per_output_sync_exclude = rnd[5:0] & 6'h3e;
    ex = r11.per_output_sync_exclude;
    wr(r11);
    pin_sync(ex);
    r11.sync_pin_io_type = PIN_PUSH_PULL;
    wr(r11);
    exp_q.push_back(~ex);
    r11.sync_polarity_invert = 1'b1;
    wr(r11);
    held(ex);
    r11.sync_polarity_invert = 1'b0;
    wr(r11);
    r11.sync_pin_io_type = PIN_INPUT;
    r11.sync_enable = 1'b0;
    wr(r11);
    sync_pin = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    cmp("sync_active", 32'h0, sync_active);
    sync_pin = 1'b0;
    exp_q.push_back(~ex);
    r11.sync_enable = 1'b1;
    wr(r11);
    r11.auto_sync = 1'b1;
    wr(r11);
    exp_q.push_back(~ex);
    wr({rnd, rnd, 11'h000, ADDR_LAST_DELAY_REG});
    wr({rnd, rnd, 11'h000, 5'h07});
    r11.auto_sync = 1'b0;
    wr(r11);
    lock_status.second_lock = 1'b0;
    exp_q.push_back(~ex);
    r12.sync_hold_until_second_lock = 1'b1;
    wr(r12);
    held(ex);
    // Exclusions written mid-sync must not touch the running participants
    r11.per_output_sync_exclude = 6'h3f;
    wr(r11);
    held(ex);
    lock_status.second_lock = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    cmp("sync_active", 32'h0, sync_active);
    // Qualified sync waits for the external feedback tick at both ends
    r11.per_output_sync_exclude = ex;
    r11.sync_qualify_by_output = 1'b1;
    wr(r11);
    exp_q.push_back(~ex);
    sync_pin = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    cmp("sync_active", 32'h0, sync_active);
    ext_fb_tick = 1'b1;
    @(posedge mclk);
    #1;
    ext_fb_tick = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    held(ex);
    sync_pin = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    cmp("sync_active", 32'h1, sync_active);
    ext_fb_tick = 1'b1;
    @(posedge mclk);
    #1;
    ext_fb_tick = 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    cmp("sync_active", 32'h0, sync_active);
    // Output two divider off: qualification drops to plain sync
    div2_pd = 1'b1;
    pin_sync(ex);
    div2_pd = 1'b0;
    // Written twice so both the old and new word carry a set top bit
    r11.mode = MODE_DISTRIBUTION;
    r11.sync_pin_io_type = PIN_PUSH_PULL;
    r11.sync_pin_output_select = SPS_READBACK;
    wr(r11);
    wr(r11);
    cmp("sync_pin", 32'h1, sync_o);
    cmp("pending", 32'h0, exp_q.size());
    wrap_up();
  end
endmodule : tb
`default_nettype wire
